//--- hw/mis_consts.svh
// Constants of the instruction execution tail: widths, offsets, resets.
// Assumes inclusion by bare name from the package and the execution unit.
`ifndef MIS_CONSTS_SVH
`define MIS_CONSTS_SVH
`define MIS_DW 8
`define MIS_PW 16
`define MIS_PAW 12
`define MIS_PAGEW 4
`define MIS_SECW 2
`define MIS_MEMD 1024
`define MIS_BAW 11
`define MIS_OPW 5
`define MIS_BUS_MEM_BIT 10
`define MIS_OFS_ACC 11'h000
`define MIS_OFS_STATUS 11'h001
`define MIS_OFS_TABLE_POINTER_LOW 11'h002
`define MIS_OFS_TABLE_POINTER_HIGH 11'h003
`define MIS_OFS_TABLE_UPPER_BYTE_LATCH 11'h004
`define MIS_OFS_SECT 11'h005
`define MIS_FLAG_C 0
`define MIS_FLAG_AC 1
`define MIS_FLAG_Z 2
`define MIS_FLAG_OV 3
`define MIS_FLAG_SC 4
`define MIS_RST_BYTE 8'h00
`define MIS_RST_SECT 2'h0
`define MIS_RST_PADDR 12'h000
`define MIS_LAST_PAGE 4'hF
`define MIS_BCD_LIMIT 4'h9
`define MIS_BCD_STEP 4'h6
`endif

//--- hw/mis_exec.sv
// Execution unit for the instruction tail: swap, skips, table reads,
// exclusive-OR and the far (any-section) data memory group.
// Assumes one core clock, a program memory answering in the same cycle as
// its address, and a core that stalls while op_ready is low.
// Functional notes
// - Swap memory nibbles into accumulator, flags kept
// - Skip next instruction when memory byte zero
// - A taken conditional skip lasts two cycles, an untaken one one cycle
// - Copy byte to accumulator, skip if zero
// - Skip next instruction when chosen bit zero
// - Table read current page via low pointer
// - Table read last page via low pointer
// - Increment low pointer, read full pointer word
// - Increment low pointer, read last page word
// - Exclusive-OR to accumulator or memory, zero flag
// - Far group addresses any memory section directly
// - Far add with carry, five flags updated
// - Far add without carry, five flags updated
// - Far AND, zero flag only
// - Far clear byte or bit, no flags
// - Far complement to memory or accumulator, zero
// - Far decimal adjust accumulator into memory
// - Decimal adjust touches only the carry flag
// - Far move either direction, no flags
`include "mis_consts.svh"
module mis_exec (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic op_valid,
  input wire mis_pkg::mis_op_t op_code,
  input wire logic [`MIS_DW-1:0] op_addr,
  input wire logic [`MIS_SECW-1:0] op_sect,
  input wire logic [2:0] op_bit,
  input wire logic [`MIS_DW-1:0] op_imm,
  input wire logic [`MIS_PAGEW-1:0] pc_page,
  output logic op_ready,
  output logic discard_fetched,
  output logic [`MIS_PAW-1:0] prog_addr,
  input wire logic [`MIS_PW-1:0] prog_word,
  input wire logic [`MIS_BAW-1:0] bus_addr,
  input wire logic [`MIS_DW-1:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [`MIS_DW-1:0] bus_rdata
);
  localparam int MEM_AW = `MIS_SECW + `MIS_DW;

  logic [`MIS_DW-1:0] mem [0:`MIS_MEMD-1];
  mis_pkg::mis_state_t state_reg, state_next;
  logic [`MIS_DW-1:0] acc_reg, acc_next;
  logic [4:0] flag_reg, flag_next;
  logic [`MIS_DW-1:0] table_pointer_low_reg, table_pointer_low_next;
  logic [`MIS_DW-1:0] table_pointer_high_reg, table_pointer_high_next;
  logic [`MIS_DW-1:0] table_upper_byte_latch_reg, table_upper_byte_latch_next;
  logic [`MIS_SECW-1:0] sect_reg, sect_next;
  logic [`MIS_PAW-1:0] paddr_reg, paddr_next;
  logic [MEM_AW-1:0] tgt_reg, tgt_next;
  logic [`MIS_DW-1:0] rdata_reg, rdata_next;
  logic mem_we;
  logic [MEM_AW-1:0] mem_wa;
  logic [`MIS_DW-1:0] mem_wd;
  logic [MEM_AW-1:0] ea;
  logic [`MIS_DW-1:0] m;
  logic [`MIS_DW:0] sum;
  logic [4:0] lo_sum;
  logic cin;
  logic [`MIS_DW-1:0] res;
  logic [`MIS_DW-1:0] bcd;
  logic bcd_carry;

  // Far operations carry their own section; the rest use the selected one
  function automatic logic is_far(input mis_pkg::mis_op_t op);
    is_far = (op >= mis_pkg::OP_FAR_ADD_CARRY_TO_ACC);
  endfunction

  // Bus offsets at or above the memory bit reach data memory directly
  function automatic logic is_mem_ofs(input logic [`MIS_BAW-1:0] a);
    is_mem_ofs = a[`MIS_BUS_MEM_BIT];
  endfunction

  // Operand fetch: memory read is combinational so execution takes one cycle, except taken skips and table reads, which take two
  always_comb begin
    if (is_far(op_code)) begin
      ea = {op_sect, op_addr};
    end else begin
      ea = {sect_reg, op_addr};
    end
    m = mem[ea];
    cin = (op_code == mis_pkg::OP_FAR_ADD_CARRY_TO_ACC) ||
          (op_code == mis_pkg::OP_FAR_ADD_CARRY_TO_MEMORY) ?
          flag_reg[`MIS_FLAG_C] : 1'b0;
    sum = {1'b0, acc_reg} + {1'b0, m} + {8'h00, cin};
    lo_sum = {1'b0, acc_reg[3:0]} + {1'b0, m[3:0]} + {4'h0, cin};
    res = sum[`MIS_DW-1:0];
  end

  // Decimal adjust: low nibble first, then high nibble, carry chains
  always_comb begin
    logic [4:0] lo;
    logic [4:0] hi;
    lo = {1'b0, acc_reg[3:0]};
    hi = {1'b0, acc_reg[7:4]};
    if (acc_reg[3:0] > `MIS_BCD_LIMIT || flag_reg[`MIS_FLAG_AC]) begin
      lo = lo + {1'b0, `MIS_BCD_STEP};
    end
    hi = hi + {4'h0, lo[4]};
    if (hi[3:0] > `MIS_BCD_LIMIT || hi[4] || flag_reg[`MIS_FLAG_C]) begin
      hi = hi + {1'b0, `MIS_BCD_STEP};
    end
    bcd = {hi[3:0], lo[3:0]};
    bcd_carry = hi[4] | flag_reg[`MIS_FLAG_C];
  end

  // Next-state logic: bus writes first, execution overrides on conflict
  always_comb begin
    state_next = state_reg;
    acc_next = acc_reg;
    flag_next = flag_reg;
    table_pointer_low_next = table_pointer_low_reg;
    table_pointer_high_next = table_pointer_high_reg;
    table_upper_byte_latch_next = table_upper_byte_latch_reg;
    sect_next = sect_reg;
    paddr_next = paddr_reg;
    tgt_next = tgt_reg;
    rdata_next = rdata_reg;
    mem_we = 1'b0;
    mem_wa = bus_addr[MEM_AW-1:0];
    mem_wd = bus_wdata;
    // Register port: read data valid from the cycle after the strobe until the next read
    if (bus_rd) begin
      if (is_mem_ofs(bus_addr)) begin
        rdata_next = mem[bus_addr[MEM_AW-1:0]];
      end else begin
        case (bus_addr)
          `MIS_OFS_ACC: rdata_next = acc_reg;
          `MIS_OFS_STATUS: rdata_next = {3'h0, flag_reg};
          `MIS_OFS_TABLE_POINTER_LOW: rdata_next = table_pointer_low_reg;
          `MIS_OFS_TABLE_POINTER_HIGH: rdata_next = table_pointer_high_reg;
          `MIS_OFS_TABLE_UPPER_BYTE_LATCH: rdata_next = table_upper_byte_latch_reg;
          `MIS_OFS_SECT: rdata_next = {6'h00, sect_reg};
          default: rdata_next = `MIS_RST_BYTE;
        endcase
      end
    end
    if (bus_wr) begin
      if (is_mem_ofs(bus_addr)) begin
        mem_we = 1'b1;
      end else begin
        case (bus_addr)
          `MIS_OFS_ACC: acc_next = bus_wdata;
          `MIS_OFS_STATUS: flag_next = bus_wdata[4:0];
          `MIS_OFS_TABLE_POINTER_LOW: table_pointer_low_next = bus_wdata;
          `MIS_OFS_TABLE_POINTER_HIGH: table_pointer_high_next = bus_wdata;
          `MIS_OFS_SECT: sect_next = bus_wdata[`MIS_SECW-1:0];
          default: ;
        endcase
      end
    end
    case (state_reg)
      mis_pkg::ST_IDLE: begin
        if (op_valid) begin
          tgt_next = ea;
          // An op that writes memory wins; otherwise the bus write goes ahead
          mem_we = 1'b0;
          case (op_code)
            mis_pkg::OP_NIBBLE_EXCHANGE_TO_ACC: begin
              acc_next = {m[3:0], m[7:4]};
            end
            mis_pkg::OP_SKIP_WHEN_ZERO: begin
              if (m == `MIS_RST_BYTE) begin
                state_next = mis_pkg::ST_SKIP;
              end
            end
            mis_pkg::OP_COPY_THEN_SKIP_WHEN_ZERO: begin
              acc_next = m;
              if (m == `MIS_RST_BYTE) begin
                state_next = mis_pkg::ST_SKIP;
              end
            end
            mis_pkg::OP_SKIP_WHEN_BIT_ZERO: begin
              if (!m[op_bit]) begin
                state_next = mis_pkg::ST_SKIP;
              end
            end
            mis_pkg::OP_TABLE_READ_CURRENT_PAGE: begin
              paddr_next = {pc_page, table_pointer_low_reg};
              state_next = mis_pkg::ST_TABLE;
            end
            mis_pkg::OP_TABLE_READ_FINAL_PAGE: begin
              paddr_next = {`MIS_LAST_PAGE, table_pointer_low_reg};
              state_next = mis_pkg::ST_TABLE;
            end
            mis_pkg::OP_PREINC_TABLE_READ: begin
              table_pointer_low_next = table_pointer_low_reg + 8'h01;
              paddr_next = {table_pointer_high_reg[`MIS_PAGEW-1:0], table_pointer_low_next};
              state_next = mis_pkg::ST_TABLE;
            end
            mis_pkg::OP_PREINC_TABLE_READ_FINAL_PAGE: begin
              table_pointer_low_next = table_pointer_low_reg + 8'h01;
              paddr_next = {`MIS_LAST_PAGE, table_pointer_low_next};
              state_next = mis_pkg::ST_TABLE;
            end
            mis_pkg::OP_EXCLUSIVE_OR_TO_ACC: begin
              acc_next = acc_reg ^ m;
              flag_next[`MIS_FLAG_Z] = (acc_next == `MIS_RST_BYTE);
            end
            mis_pkg::OP_EXCLUSIVE_OR_INTO_MEMORY: begin
              mem_we = 1'b1;
              mem_wd = acc_reg ^ m;
              flag_next[`MIS_FLAG_Z] = (mem_wd == `MIS_RST_BYTE);
            end
            mis_pkg::OP_EXCLUSIVE_OR_IMM: begin
              acc_next = acc_reg ^ op_imm;
              flag_next[`MIS_FLAG_Z] = (acc_next == `MIS_RST_BYTE);
            end
            mis_pkg::OP_FAR_ADD_CARRY_TO_ACC, mis_pkg::OP_FAR_SUM_TO_ACC,
            mis_pkg::OP_FAR_ADD_CARRY_TO_MEMORY, mis_pkg::OP_FAR_SUM_TO_MEMORY: begin
              // Overflow is a sign change of like-signed operands
              flag_next[`MIS_FLAG_C] = sum[`MIS_DW];
              flag_next[`MIS_FLAG_AC] = lo_sum[4];
              flag_next[`MIS_FLAG_Z] = (res == `MIS_RST_BYTE);
              flag_next[`MIS_FLAG_OV] = (acc_reg[7] == m[7]) && (res[7] != acc_reg[7]);
              flag_next[`MIS_FLAG_SC] = flag_next[`MIS_FLAG_OV] ^ res[7];
              if (op_code == mis_pkg::OP_FAR_ADD_CARRY_TO_ACC ||
                  op_code == mis_pkg::OP_FAR_SUM_TO_ACC) begin
                acc_next = res;
              end else begin
                mem_we = 1'b1;
                mem_wd = res;
              end
            end
            mis_pkg::OP_FAR_CONJUNCTION_TO_ACC: begin
              acc_next = acc_reg & m;
              flag_next[`MIS_FLAG_Z] = (acc_next == `MIS_RST_BYTE);
            end
            mis_pkg::OP_FAR_CONJUNCTION_TO_MEMORY: begin
              mem_we = 1'b1;
              mem_wd = acc_reg & m;
              flag_next[`MIS_FLAG_Z] = (mem_wd == `MIS_RST_BYTE);
            end
            mis_pkg::OP_FAR_ZERO_FILL: begin
              mem_we = 1'b1;
              mem_wd = `MIS_RST_BYTE;
            end
            mis_pkg::OP_FAR_ZERO_FILL_BIT: begin
              mem_we = 1'b1;
              mem_wd = m;
              mem_wd[op_bit] = 1'b0;
            end
            mis_pkg::OP_FAR_INVERT: begin
              mem_we = 1'b1;
              mem_wd = ~m;
              flag_next[`MIS_FLAG_Z] = (mem_wd == `MIS_RST_BYTE);
            end
            mis_pkg::OP_FAR_INVERT_TO_ACC: begin
              acc_next = ~m;
              flag_next[`MIS_FLAG_Z] = (acc_next == `MIS_RST_BYTE);
            end
            mis_pkg::OP_FAR_BCD_FIXUP: begin
              mem_we = 1'b1;
              mem_wd = bcd;
              flag_next[`MIS_FLAG_C] = bcd_carry;
            end
            mis_pkg::OP_FAR_MINUS_ONE: begin
              mem_we = 1'b1;
              mem_wd = m - 8'h01;
              flag_next[`MIS_FLAG_Z] = (mem_wd == `MIS_RST_BYTE);
            end
            mis_pkg::OP_FAR_MINUS_ONE_TO_ACC: begin
              acc_next = m - 8'h01;
              flag_next[`MIS_FLAG_Z] = (acc_next == `MIS_RST_BYTE);
            end
            mis_pkg::OP_FAR_PLUS_ONE: begin
              mem_we = 1'b1;
              mem_wd = m + 8'h01;
              flag_next[`MIS_FLAG_Z] = (mem_wd == `MIS_RST_BYTE);
            end
            mis_pkg::OP_FAR_PLUS_ONE_TO_ACC: begin
              acc_next = m + 8'h01;
              flag_next[`MIS_FLAG_Z] = (acc_next == `MIS_RST_BYTE);
            end
            mis_pkg::OP_FAR_COPY_TO_ACC: begin
              acc_next = m;
            end
            mis_pkg::OP_FAR_COPY_TO_MEMORY: begin
              mem_we = 1'b1;
              mem_wd = acc_reg;
            end
            default: ;
          endcase
          // Keep the bus address unless the op itself writes memory
          if (mem_we) begin
            mem_wa = ea;
          end else begin
            mem_we = bus_wr && is_mem_ofs(bus_addr);
          end
        end
      end
      mis_pkg::ST_SKIP: begin
        // Dummy cycle: the core drops the instruction fetched meanwhile
        state_next = mis_pkg::ST_IDLE;
      end
      mis_pkg::ST_TABLE: begin
        // Program word arrives now; low byte to memory, high to latch
        mem_we = 1'b1;
        mem_wa = tgt_reg;
        mem_wd = prog_word[`MIS_DW-1:0];
        table_upper_byte_latch_next = prog_word[`MIS_PW-1:`MIS_DW];
        state_next = mis_pkg::ST_IDLE;
      end
      default: state_next = mis_pkg::ST_IDLE;
    endcase
  end

  // Control state registers
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= mis_pkg::ST_IDLE;
      acc_reg <= `MIS_RST_BYTE;
      flag_reg <= 5'h00;
      table_pointer_low_reg <= `MIS_RST_BYTE;
      table_pointer_high_reg <= `MIS_RST_BYTE;
      table_upper_byte_latch_reg <= `MIS_RST_BYTE;
      sect_reg <= `MIS_RST_SECT;
      paddr_reg <= `MIS_RST_PADDR;
      tgt_reg <= '0;
      rdata_reg <= `MIS_RST_BYTE;
    end else begin
      state_reg <= state_next;
      acc_reg <= acc_next;
      flag_reg <= flag_next;
      table_pointer_low_reg <= table_pointer_low_next;
      table_pointer_high_reg <= table_pointer_high_next;
      table_upper_byte_latch_reg <= table_upper_byte_latch_next;
      sect_reg <= sect_next;
      paddr_reg <= paddr_next;
      tgt_reg <= tgt_next;
      rdata_reg <= rdata_next;
    end
  end

  // Data memory has no reset; contents are undefined until written
  always_ff @(posedge clk) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
  end

  // Outputs: handshakes combinational, data from flops
  assign op_ready = (state_reg == mis_pkg::ST_IDLE);
  assign discard_fetched = (state_reg == mis_pkg::ST_SKIP);
  assign prog_addr = paddr_reg;
  assign bus_rdata = rdata_reg;
endmodule

//--- hw/mis_pkg.sv
// Types of the instruction execution tail: operation codes and states.
// Assumes mis_consts.svh is on the include path.
`include "mis_consts.svh"
package mis_pkg;
  typedef enum logic [`MIS_OPW-1:0] {
    OP_NOP = 5'h00,
    OP_NIBBLE_EXCHANGE_TO_ACC = 5'h01,
    OP_SKIP_WHEN_ZERO = 5'h02,
    OP_COPY_THEN_SKIP_WHEN_ZERO = 5'h03,
    OP_SKIP_WHEN_BIT_ZERO = 5'h04,
    OP_TABLE_READ_CURRENT_PAGE = 5'h05,
    OP_TABLE_READ_FINAL_PAGE = 5'h06,
    OP_PREINC_TABLE_READ = 5'h07,
    OP_PREINC_TABLE_READ_FINAL_PAGE = 5'h08,
    OP_EXCLUSIVE_OR_TO_ACC = 5'h09,
    OP_EXCLUSIVE_OR_INTO_MEMORY = 5'h0A,
    OP_EXCLUSIVE_OR_IMM = 5'h0B,
    OP_FAR_ADD_CARRY_TO_ACC = 5'h0C,
    OP_FAR_ADD_CARRY_TO_MEMORY = 5'h0D,
    OP_FAR_SUM_TO_ACC = 5'h0E,
    OP_FAR_SUM_TO_MEMORY = 5'h0F,
    OP_FAR_CONJUNCTION_TO_ACC = 5'h10,
    OP_FAR_CONJUNCTION_TO_MEMORY = 5'h11,
    OP_FAR_ZERO_FILL = 5'h12,
    OP_FAR_ZERO_FILL_BIT = 5'h13,
    OP_FAR_INVERT = 5'h14,
    OP_FAR_INVERT_TO_ACC = 5'h15,
    OP_FAR_BCD_FIXUP = 5'h16,
    OP_FAR_MINUS_ONE = 5'h17,
    OP_FAR_MINUS_ONE_TO_ACC = 5'h18,
    OP_FAR_PLUS_ONE = 5'h19,
    OP_FAR_PLUS_ONE_TO_ACC = 5'h1A,
    OP_FAR_COPY_TO_ACC = 5'h1B,
    OP_FAR_COPY_TO_MEMORY = 5'h1C
  } mis_op_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SKIP = 2'b01,
    ST_TABLE = 2'b10
  } mis_state_t;
endpackage

//--- tb/mis_exec_properties.sv
// Checker for the execution tail: dummy cycle of skips and table fetches.
// Assumes it is bound to mis_exec and sees only that module's ports.
module mis_exec_properties (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic op_valid,
  input wire mis_pkg::mis_op_t op_code,
  input wire logic [3:0] pc_page,
  input wire logic op_ready,
  input wire logic discard_fetched,
  input wire logic [11:0] prog_addr
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic tk;
  logic sk;
  logic tr;
  logic lp;
  // Decode of the taken request; ranges follow the opcode order
  assign tk = op_valid && op_ready;
  assign sk = op_code inside {[mis_pkg::OP_SKIP_WHEN_ZERO:mis_pkg::OP_SKIP_WHEN_BIT_ZERO]};
  assign tr = op_code inside
    {[mis_pkg::OP_TABLE_READ_CURRENT_PAGE:mis_pkg::OP_PREINC_TABLE_READ_FINAL_PAGE]};
  assign lp = op_code == mis_pkg::OP_TABLE_READ_FINAL_PAGE ||
    op_code == mis_pkg::OP_PREINC_TABLE_READ_FINAL_PAGE;
  chk_discard_busy: assert property (discard_fetched |-> !op_ready)
    else $error("dummy cycle while ready");
  chk_skip_two_cycles: assert property (
    discard_fetched |=> op_ready && !discard_fetched)
    else $error("skip longer than two cycles");
  chk_discard_cause: assert property (
    discard_fetched |-> $past(tk) && $past(sk))
    else $error("discard without a taken skip");
  chk_nonskip_quiet: assert property (tk && !sk |=> !discard_fetched)
    else $error("discard after a non-skip op");
  chk_table_busy: assert property (
    tk && tr |=> !op_ready ##1 op_ready)
    else $error("table read not two cycles");
  chk_last_page: assert property (
    tk && lp |=> prog_addr[11:8] == 4'hF)
    else $error("last page not addressed");
  chk_current_page: assert property (
    tk && op_code == mis_pkg::OP_TABLE_READ_CURRENT_PAGE |=>
    prog_addr[11:8] == $past(pc_page))
    else $error("current page not addressed");
  chk_addr_held: assert property (!(tk && tr) |=> $stable(prog_addr))
    else $error("program address moved");
  chk_ready_returns: assert property (!op_ready |=> op_ready)
    else $error("busy longer than one cycle");
endmodule
bind mis_exec mis_exec_properties chk_inst (.clk(clk), .sys_rst(sys_rst),
  .op_valid(op_valid), .op_code(op_code), .pc_page(pc_page), .op_ready(op_ready),
  .discard_fetched(discard_fetched), .prog_addr(prog_addr));

//--- tb/mis_exec_test.sv
// Testbench for mis_exec: bus tasks, an op task and a table of cases.
// Assumes program memory answers within the cycle after prog_addr moves.
`include "mis_consts.svh"
module mis_exec_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic op_valid = 1'b0;
  logic bus_wr = 1'b0;
  logic bus_rd = 1'b0;
  logic op_ready, discard_fetched;
  mis_pkg::mis_op_t op_code = mis_pkg::OP_NOP;
  logic [7:0] op_addr = 8'h30;
  logic [7:0] op_imm = 8'h5A;
  logic [7:0] bus_wdata = 8'h00;
  logic [7:0] bus_rdata;
  logic [1:0] op_sect = 2'h2;
  logic [2:0] op_bit = 3'h0;
  logic [3:0] pc_page = 4'h3;
  logic [11:0] prog_addr;
  logic [15:0] prog_word;
  logic [10:0] bus_addr = 11'h000;
  logic [10:0] a;
  logic [63:0] r;
  int num_errors = 0;
  int check_count = 0;
  logic [11:0] ta [4] = '{12'h3FE, 12'hFFE, 12'h5FF, 12'hF00};
  // Row: op, bit, skip, acc, mem, status, then acc, mem, status after
  logic [63:0] rows [30] = '{
    64'h02_01_11_00_1B_11_00_1B,
    64'h02_00_11_01_04_11_01_04,
    64'h03_01_11_00_00_00_00_00,
    64'h03_00_11_80_1B_80_80_1B,
    64'h04_31_11_F7_00_11_F7_00,
    64'h04_70_11_80_00_11_80_00,
    64'h01_00_00_3C_1B_C3_3C_1B,
    64'h09_00_3C_3C_1B_00_3C_1F,
    64'h0A_00_55_3C_04_55_69_00,
    64'h0B_00_A5_00_00_FF_00_00,
    64'h0C_00_FF_00_01_00_00_07,
    64'h0D_00_7F_00_01_7F_80_0A,
    64'h0E_00_88_88_01_10_88_1B,
    64'h0F_00_01_FF_00_01_00_07,
    64'h10_00_F0_0F_1B_00_0F_1F,
    64'h11_00_F0_3C_04_F0_30_00,
    64'h12_00_00_FF_1F_00_00_1F,
    64'h13_30_00_08_00_00_00_00,
    64'h14_00_12_00_04_12_FF_00,
    64'h15_00_12_FF_00_00_FF_04,
    64'h16_00_A3_00_1E_A3_09_1F,
    64'h16_00_2B_00_00_2B_31_00,
    64'h16_00_23_00_02_23_29_02,
    64'h16_00_12_00_01_12_72_01,
    64'h17_00_55_01_00_55_00_04,
    64'h18_00_55_00_04_FF_00_00,
    64'h19_00_55_FF_1B_55_00_1F,
    64'h1A_00_55_7F_00_80_7F_00,
    64'h1B_00_5A_00_1B_00_00_1B,
    64'h1C_00_A5_00_00_A5_A5_00};

  mis_exec dut (.clk(clk), .sys_rst(sys_rst), .op_valid(op_valid), .op_code(op_code),
    .op_addr(op_addr), .op_sect(op_sect), .op_bit(op_bit), .op_imm(op_imm),
    .pc_page(pc_page), .op_ready(op_ready), .discard_fetched(discard_fetched),
    .prog_addr(prog_addr), .prog_word(prog_word), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata));

  // Clock, 10 ns period
  initial begin
    forever #5 clk = ~clk;
  end

  // Program memory: asynchronous read, so the word settles within the cycle
  assign prog_word = {4'hA, prog_addr};

  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    check_count++;
    if (s !== e) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, s, e);
    end
  endtask

  // Bus cycles leave one idle cycle so a strobe is never set twice at once
  task automatic wr(input logic [10:0] ad, input logic [7:0] d);
    bus_addr <= ad;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge clk);
    bus_wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [10:0] ad, input logic [7:0] e);
    bus_addr <= ad;
    bus_rd <= 1'b1;
    @(posedge clk);
    bus_rd <= 1'b0;
    #1 chk(bus_rdata, e);
    @(posedge clk);
  endtask

  // One op; the dummy-cycle pulse is looked at in the cycle after the take
  task automatic op(input logic [7:0] c, input logic [2:0] b, input logic d);
    op_code <= mis_pkg::mis_op_t'(c[4:0]);
    op_bit <= b;
    op_valid <= 1'b1;
    @(posedge clk);
    op_valid <= 1'b0;
    #1 chk(discard_fetched, d);
    @(posedge clk);
  endtask

  task automatic report_and_stop;
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Hang guard
  initial begin
    repeat (30000) @(posedge clk);
    num_errors++;
    report_and_stop;
  end

  // Main sequence
  initial begin
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 7; i++) rd(11'(i), 8'h00);
    wr(`MIS_OFS_TABLE_UPPER_BYTE_LATCH, 8'hFF);
    rd(`MIS_OFS_TABLE_UPPER_BYTE_LATCH, 8'h00);
    wr(`MIS_OFS_SECT, 8'h01);
    wr(`MIS_OFS_TABLE_POINTER_LOW, 8'hFE);
    wr(`MIS_OFS_TABLE_POINTER_HIGH, 8'h05);
    for (int i = 0; i < 4; i++) begin
      op(8'h05 + 8'(i), 3'h0, 1'b0);
      chk(prog_addr, ta[i]);
      rd(11'h530, ta[i][7:0]);
      rd(`MIS_OFS_TABLE_UPPER_BYTE_LATCH, {4'hA, ta[i][11:8]});
    end
    rd(`MIS_OFS_TABLE_POINTER_LOW, 8'h00);
    rd(`MIS_OFS_TABLE_POINTER_HIGH, 8'h05);
    // Near ops use section 1, far ops section 2 of the same offset
    foreach (rows[i]) begin
      r = rows[i];
      a = (r[63:56] > 8'h0B) ? 11'h630 : 11'h530;
      wr(`MIS_OFS_ACC, r[47:40]);
      wr(a, r[39:32]);
      wr(`MIS_OFS_STATUS, r[31:24]);
      op(r[63:56], r[54:52], r[48]);
      rd(`MIS_OFS_ACC, r[23:16]);
      rd(a, r[15:8]);
      rd(`MIS_OFS_STATUS, r[7:0]);
    end
    // Two increments back to back, then a skip with the request held
    wr(11'h630, 8'hFE);
    wr(11'h530, 8'h00);
    op_code <= mis_pkg::OP_FAR_PLUS_ONE;
    op_valid <= 1'b1;
    @(posedge clk);
    @(posedge clk);
    op_code <= mis_pkg::OP_SKIP_WHEN_ZERO;
    @(posedge clk);
    #1 chk(discard_fetched, 1'b1);
    @(posedge clk);
    op_valid <= 1'b0;
    #1 chk(discard_fetched, 1'b0);
    @(posedge clk);
    rd(11'h630, 8'h00);
    report_and_stop;
  end
endmodule
